//--- rtl/load_step_config.sv
// APB register block and supervision for load-dependent stepping.
// Assumes ramp velocity and fullstep release come from pclk logic and
// the driver feedback arrives asynchronously on a pin.
`timescale 1ns/1ps

module load_step_config (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [load_step_pkg::ADDR_W-1:0] paddr,
    input wire logic [load_step_pkg::DATA_W-1:0] pwdata,
    output logic [load_step_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [load_step_pkg::DATA_W-1:0] actual_ramp_velocity,
    input wire logic fullstep_release,
    input wire logic driver_feedback,
    output logic load_step_active,
    output logic [load_step_pkg::VEL_W-1:0] emf_comp_start_velocity,
    output logic [load_step_pkg::VEL_W-1:0] fullstep_switch_velocity,
    output logic [load_step_pkg::VEL_W-1:0] emf_comp_extra_velocity,
    output logic [load_step_pkg::VEL_W-1:0] encoder_standstill_delay,
    output logic [load_step_pkg::ON_LIMIT_W-1:0] commutation_on_time_limit,
    output logic commutation_cut,
    output logic stall_event,
    output logic irq
);
    import load_step_pkg::*;

    // ************************************************************
    // Register storage.
    // ************************************************************
    logic [VEL_W-1:0] min_velocity_for_load_stepping;
    logic [DATA_W-1:0] step_cfg;
    logic [DATA_W-1:0] low_speed_timeout;
    logic [CTRL_W-1:0] ctrl;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] int_mask;
    logic [STATUS_W-1:0] next_status;
    logic [DATA_W-1:0] ls_cnt;
    logic fb_meta;
    logic fb_sync;

    // ************************************************************
    // APB decode.
    // ************************************************************
    wire [IDX_W-1:0] idx = paddr[ADDR_W-1:IDX_SHIFT];
    wire aligned = paddr[IDX_SHIFT-1:0] == '0;
    wire hit_min = aligned & (idx == IDX_MIN_VEL);
    wire hit_cfg = aligned & (idx == IDX_STEP_CFG);
    wire hit_lsptm = aligned & (idx == IDX_LSPTM);
    wire hit_ctrl = aligned & (idx == IDX_CTRL);
    wire hit_status = aligned & (idx == IDX_STATUS);
    wire hit_mask = aligned & (idx == IDX_MASK);
    wire hit_state = aligned & (idx == IDX_STATE);
    wire mapped = hit_min | hit_cfg | hit_lsptm | hit_ctrl | hit_status |
        hit_mask | hit_state;
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr_done = access & pwrite & mapped;
    wire rd_status = access & ~pwrite & hit_status;

    assign pready = access;
    assign pslverr = access & ~mapped;

    // ************************************************************
    // Read data, captured in the setup cycle; write-only words read 0.
    // ************************************************************
    logic [STATE_W-1:0] state_view;
    logic [DATA_W-1:0] rd_mux;
    wire det_blanking;
    wire det_measuring;
    assign state_view = {det_measuring, det_blanking, load_step_active};
    assign rd_mux = hit_ctrl ? DATA_W'(ctrl) :
        hit_status ? DATA_W'(status) :
        hit_mask ? DATA_W'(int_mask) :
        hit_state ? DATA_W'(state_view) : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup) begin
            prdata <= rd_mux;
        end
    end

    // ************************************************************
    // Register writes.
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            min_velocity_for_load_stepping <= MIN_VEL_RST;
            step_cfg <= STEP_CFG_RST;
            low_speed_timeout <= LSPTM_RST;
            ctrl <= CTRL_RST;
            int_mask <= STATUS_RST;
        end else if (wr_done) begin
            if (hit_min) begin
                min_velocity_for_load_stepping <= pwdata[VEL_W-1:0];
            end
            if (hit_cfg) begin
                step_cfg <= pwdata;
            end
            if (hit_lsptm) begin
                low_speed_timeout <= pwdata;
            end
            if (hit_ctrl) begin
                ctrl <= pwdata[CTRL_W-1:0];
            end
            if (hit_mask) begin
                int_mask <= pwdata[STATUS_W-1:0];
            end
        end
    end

    // ************************************************************
    // Mode selection and shared storage views.
    // ************************************************************
    wire load_en = ctrl[CTRL_LOAD_EN];
    wire cl_en = ctrl[CTRL_CL_EN];
    wire [DATA_W-1:0] abs_vel = actual_ramp_velocity[DATA_W-1] ?
        DATA_W'(-actual_ramp_velocity) : DATA_W'(actual_ramp_velocity);
    wire vel_above = abs_vel > DATA_W'(min_velocity_for_load_stepping);
    wire next_active = load_en & ~cl_en & vel_above;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_step_active <= 1'b0;
            emf_comp_start_velocity <= '0;
            fullstep_switch_velocity <= '0;
            emf_comp_extra_velocity <= '0;
            encoder_standstill_delay <= '0;
            commutation_on_time_limit <= '0;
        end else begin
            load_step_active <= next_active;
            emf_comp_start_velocity <= cl_en ?
                min_velocity_for_load_stepping : '0;
            fullstep_switch_velocity <= (!cl_en && !load_en) ?
                min_velocity_for_load_stepping : '0;
            emf_comp_extra_velocity <= cl_en ? step_cfg[VEL_W-1:0] : '0;
            encoder_standstill_delay <= load_en ? '0 :
                low_speed_timeout[VEL_W-1:0];
            commutation_on_time_limit <=
                step_cfg[ON_LIMIT_LSB+ON_LIMIT_W-1:ON_LIMIT_LSB];
        end
    end

    // ************************************************************
    // Feedback pin synchroniser.
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_meta <= 1'b0;
            fb_sync <= 1'b0;
        end else begin
            fb_meta <= driver_feedback;
            fb_sync <= fb_meta;
        end
    end

    // ************************************************************
    // Step-loss detector.
    // ************************************************************
    step_cfg_if link (
        .pclk(pclk),
        .presetn(presetn)
    );
    assign link.active = load_step_active;
    assign link.step_release = fullstep_release;
    assign link.feedback = fb_sync;
    assign link.blank_interval =
        step_cfg[BLANK_LSB+BLANK_W-1:BLANK_LSB];
    assign link.threshold = step_cfg[THRESH_LSB+THRESH_W-1:THRESH_LSB];
    assign link.on_limit =
        step_cfg[ON_LIMIT_LSB+ON_LIMIT_W-1:ON_LIMIT_LSB];
    assign det_blanking = link.blanking;
    assign det_measuring = link.measuring;
    assign commutation_cut = link.cut;
    assign stall_event = link.stall;

    step_loss_detect u_detect (
        .bus(link.det)
    );

    // ************************************************************
    // Low speed timer.
    // ************************************************************
    wire [DATA_W-1:0] ls_next = DATA_W'(ls_cnt + 32'h00000001);
    wire ls_run = load_step_active & ~fullstep_release;
    wire ls_hit = ls_run & (ls_cnt != low_speed_timeout) &
        (ls_next == low_speed_timeout);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_cnt <= '0;
        end else if (!ls_run) begin
            ls_cnt <= '0;
        end else if (ls_cnt != low_speed_timeout) begin
            ls_cnt <= ls_next;
        end
    end

    // ************************************************************
    // Sticky status and interrupt.
    // ************************************************************
    wire [STATUS_W-1:0] set_bits = {ls_hit, link.stall};
    wire [STATUS_W-1:0] clr_bits = rd_status ? prdata[STATUS_W-1:0] : '0;
    assign next_status = (status & ~clr_bits) | set_bits;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= STATUS_RST;
        end else begin
            status <= next_status;
        end
    end

    assign irq = |(status & int_mask);

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    active_on_a: assert property (next_active |=> load_step_active)
        else $error("mode not active above minimum velocity");
    active_off_a: assert property (
        (abs_vel <= DATA_W'(min_velocity_for_load_stepping)) |=>
        !load_step_active)
        else $error("mode active at or below minimum velocity");
    stall_sticky_a: assert property (
        link.stall |=> status[ST_STALL] ##1 (status[ST_STALL] || rd_status))
        else $error("stall not latched");
    stall_once_a: assert property (
        (rd_status && prdata[ST_STALL] && !link.stall) |=> !status[ST_STALL])
        else $error("stall flag not cleared by read");
    low_speed_a: assert property (ls_hit |=> status[ST_LOW_SPEED])
        else $error("low speed timeout not flagged");
    share_view_a: assert property (
        (cl_en && $stable(cl_en)) |=>
        emf_comp_start_velocity == $past(min_velocity_for_load_stepping))
        else $error("shared velocity view wrong");
    standstill_a: assert property (
        load_en |=> encoder_standstill_delay == '0)
        else $error("standstill delay leaks in load mode");
    irq_level_a: assert property (
        (status[ST_STALL] && int_mask[ST_STALL]) |-> irq)
        else $error("unmasked stall without interrupt");
    active_rise_c: cover property ($rose(load_step_active));
    status_read_c: cover property (rd_status && prdata[ST_STALL]);
    low_speed_c: cover property (ls_hit);
endmodule // load_step_config

//--- common/load_step_pkg.sv
// Constants shared by the load-dependent stepping logic.
// Assumes a single 40 MHz clock and an APB register port with 32-bit data.
package load_step_pkg;

    // ************************************************************
    // Bus geometry.
    // ************************************************************
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int IDX_SHIFT = 2;
    localparam int IDX_W = ADDR_W - IDX_SHIFT;

    // ************************************************************
    // Register indices; the byte address is four times the index.
    // ************************************************************
    localparam logic [IDX_W-1:0] IDX_MIN_VEL = 8'h60;
    localparam logic [IDX_W-1:0] IDX_STEP_CFG = 8'h61;
    localparam logic [IDX_W-1:0] IDX_LSPTM = 8'h62;
    localparam logic [IDX_W-1:0] IDX_CTRL = 8'h20;
    localparam logic [IDX_W-1:0] IDX_STATUS = 8'h21;
    localparam logic [IDX_W-1:0] IDX_MASK = 8'h22;
    localparam logic [IDX_W-1:0] IDX_STATE = 8'h23;

    // ************************************************************
    // Field layout.
    // ************************************************************
    localparam int VEL_W = 24;
    localparam int ON_LIMIT_LSB = 0;
    localparam int ON_LIMIT_W = 8;
    localparam int THRESH_LSB = 8;
    localparam int THRESH_W = 8;
    localparam int BLANK_LSB = 16;
    localparam int BLANK_W = 16;
    localparam int STEP_LOSS_UNIT_SHIFT = 4;
    localparam int CNT_W = 16;

    localparam int CTRL_W = 2;
    localparam int CTRL_LOAD_EN = 0;
    localparam int CTRL_CL_EN = 1;
    localparam int STATUS_W = 2;
    localparam int ST_STALL = 0;
    localparam int ST_LOW_SPEED = 1;
    localparam int STATE_W = 3;

    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [VEL_W-1:0] MIN_VEL_RST = 24'h000000;
    localparam logic [DATA_W-1:0] STEP_CFG_RST = 32'h00000000;
    localparam logic [DATA_W-1:0] LSPTM_RST = 32'h00FFFFFF;
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
    localparam logic [STATUS_W-1:0] STATUS_RST = 2'h0;

    typedef enum {DET_IDLE, DET_BLANK, DET_MEASURE} det_state_t;

endpackage

//--- common/step_cfg_if.sv
// Carries settings to the step-loss detector and its results back.
// Assumes both ends run on the same pclk and presetn.
`timescale 1ns/1ps
interface step_cfg_if (
    input wire logic pclk,
    input wire logic presetn
);
    import load_step_pkg::*;
    logic active;
    logic step_release;
    logic feedback;
    logic [BLANK_W-1:0] blank_interval;
    logic [THRESH_W-1:0] threshold;
    logic [ON_LIMIT_W-1:0] on_limit;
    logic stall;
    logic cut;
    logic blanking;
    logic measuring;

    modport cfg (
        input pclk, presetn, stall, cut, blanking, measuring,
        output active, step_release, feedback, blank_interval, threshold,
        output on_limit
    );
    modport det (
        input pclk, presetn, active, step_release, feedback,
        input blank_interval, threshold, on_limit,
        output stall, cut, blanking, measuring
    );
endinterface

//--- rtl/step_loss_detect.sv
// Blanks the driver feedback after each fullstep release while active and times the
// first regular step; assumes feedback is already synchronised to pclk.
`timescale 1ns/1ps
module step_loss_detect (
    step_cfg_if.det bus
);
    import load_step_pkg::*;

    // ************************************************************
    // Blank and measure sequencer.
    // ************************************************************
    det_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] on_cnt;
    logic fb_prev;
    wire fb_rise = bus.feedback & ~fb_prev;
    wire start = bus.step_release & bus.active;
    wire [CNT_W-1:0] thr_cycles =
        CNT_W'({bus.threshold, STEP_LOSS_UNIT_SHIFT'(0)});
    wire blank_done = cnt >= bus.blank_interval;
    wire short_step = fb_rise & (cnt < thr_cycles);
    wire cnt_full = &cnt;
    wire on_full = &on_cnt;
    wire in_step = state != DET_IDLE;
    wire on_hit = in_step & ~start & (bus.on_limit != '0) &
        (on_cnt == CNT_W'(bus.on_limit));

    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            state <= DET_IDLE;
            cnt <= '0;
            on_cnt <= '0;
            fb_prev <= 1'b0;
            bus.stall <= 1'b0;
            bus.cut <= 1'b0;
        end else begin
            fb_prev <= bus.feedback;
            bus.stall <= 1'b0;
            bus.cut <= on_hit;
            on_cnt <= start ? '0 : (on_full ? on_cnt : on_cnt + 1'b1);
            if (start) begin
                state <= DET_BLANK;
                cnt <= '0;
            end else begin
                case (state)
                    DET_IDLE: begin
                        cnt <= '0;
                    end
                    DET_BLANK: begin
                        if (blank_done) begin
                            state <= DET_MEASURE;
                            cnt <= '0;
                        end else begin
                            cnt <= cnt + 1'b1;
                        end
                    end
                    DET_MEASURE: begin
                        if (fb_rise || cnt_full || !bus.active) begin
                            state <= DET_IDLE;
                            bus.stall <= short_step;
                        end
                        cnt <= cnt + 1'b1;
                    end
                    default: begin
                        state <= DET_IDLE;
                    end
                endcase
            end
        end
    end

    assign bus.blanking = state == DET_BLANK;
    assign bus.measuring = state == DET_MEASURE;

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking @(posedge bus.pclk); endclocking
    default disable iff (!bus.presetn);

    blank_start_a: assert property (start |=> bus.blanking)
        else $error("blanking did not start on release");
    blank_hold_a: assert property (
        (bus.blanking && !blank_done && !start) |=> bus.blanking)
        else $error("blanking ended early");
    blank_quiet_a: assert property ($past(bus.blanking) |-> !bus.stall)
        else $error("stall raised during blanking");
    short_stall_a: assert property (
        (bus.measuring && !start && short_step) |=> bus.stall)
        else $error("short first step not flagged");
    long_quiet_a: assert property (
        (bus.measuring && fb_rise && !short_step) |=> !bus.stall)
        else $error("stall on a long step");
    cut_time_a: assert property (
        bus.cut |-> $past(on_cnt) == CNT_W'($past(bus.on_limit)))
        else $error("on-time cut at wrong count");
    stall_seen_c: cover property (bus.measuring ##1 bus.stall);
    cut_seen_c: cover property (bus.blanking ##[1:50] bus.cut);
endmodule // step_loss_detect

//--- verif/stepper_driver_model.sv
// Behavioural stepper driver that answers each fullstep release.
// Assumes release is a one-cycle pclk pulse from the bench, shared with the block under test.
`timescale 1ns/1ps
module stepper_driver_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fullstep_release,
    input wire logic [15:0] step_len,
    output logic driver_feedback
);
    logic [15:0] cnt;
    logic [2:0] hold;

    // ************************************************************
    // Feedback goes high step_len cycles after release, for 4 cycles.
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 16'h0000;
            hold <= 3'h0;
            driver_feedback <= 1'b0;
        end else if (fullstep_release) begin
            cnt <= step_len;
            hold <= 3'h0;
            driver_feedback <= 1'b0;
        end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
            if (cnt == 16'h0001) begin
                hold <= 3'h4;
                driver_feedback <= 1'b1;
            end
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
            driver_feedback <= (hold != 3'h1);
        end
    end
endmodule // stepper_driver_model

//--- verif/tb_load_dependent_step_config.sv
// Self-checking bench for the load-dependent stepping register block.
// Assumes the design package and a stepper driver model are compiled.
`timescale 1ns/1ps
module tb_load_dependent_step_config;
    import load_step_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata, rd;
    logic pready, pslverr, err, act, cut, stall, irq, fb;
    logic signed [DATA_W-1:0] vel = 32'sh0;
    logic rel = 1'b0;
    logic [VEL_W-1:0] emf_s, fs_v, emf_x, enc_z;
    logic [ON_LIMIT_W-1:0] lim;
    logic [15:0] step_len = 16'h000A;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;
    int stall_seen = 0;
    int cut_seen = 0;

    load_step_config DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .actual_ramp_velocity(vel),
        .fullstep_release(rel), .driver_feedback(fb),
        .load_step_active(act), .emf_comp_start_velocity(emf_s),
        .fullstep_switch_velocity(fs_v), .emf_comp_extra_velocity(emf_x),
        .encoder_standstill_delay(enc_z), .commutation_on_time_limit(lim),
        .commutation_cut(cut), .stall_event(stall), .irq(irq));
    stepper_driver_model drv (.pclk(pclk), .presetn(presetn),
        .fullstep_release(rel), .step_len(step_len), .driver_feedback(fb));

    // ************************************************************
    // Clock, reset, event monitors and timeout.
    // ************************************************************
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (stall === 1'b1) stall_seen++;
        if (cut === 1'b1) cut_seen++;
        if (cycles == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ************************************************************
    // Shared tasks.
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wreg(input logic [IDX_W-1:0] i, input logic [31:0] d);
        apb(1'b1, {i, 2'b00}, d);
    endtask
    task automatic rreg(input logic [IDX_W-1:0] i);
        apb(1'b0, {i, 2'b00}, 32'h00000000);
    endtask
    task automatic release_step(input logic [15:0] n, input int wait_n);
        step_len <= n;
        @(posedge pclk);
        rel <= 1'b1;
        @(posedge pclk);
        rel <= 1'b0;
        repeat (wait_n) @(posedge pclk);
    endtask

    // ************************************************************
    // Scenarios.
    // ************************************************************
    task automatic test_reset();
        repeat (2) @(posedge pclk);
        check("standstill", 32'(enc_z), 32'h00FFFFFF);
        rreg(IDX_LSPTM);
        check("timer read", rd, 32'h00000000);
        rreg(IDX_STATUS);
        check("status", rd, 32'h00000000);
        apb(1'b0, 10'h3F0, 32'h00000000);
        check("unmapped err", 32'(err), 32'h00000001);
        $display("test reset done");
    endtask
    task automatic test_mux();
        wreg(IDX_MIN_VEL, 32'hFF123456);
        wreg(IDX_STEP_CFG, 32'h00ABCDEF);
        wreg(IDX_LSPTM, 32'h89654321);
        wreg(IDX_CTRL, 32'h00000000);
        repeat (3) @(posedge pclk);
        check("fullstep_switch_velocity", 32'(fs_v), 32'h00123456);
        check("emf start", 32'(emf_s), 32'h00000000);
        check("on limit", 32'(lim), 32'h000000EF);
        check("standstill", 32'(enc_z), 32'h00654321);
        check("emf extra", 32'(emf_x), 32'h00000000);
        wreg(IDX_CTRL, 32'h00000002);
        repeat (3) @(posedge pclk);
        check("emf start", 32'(emf_s), 32'h00123456);
        check("fullstep_switch_velocity", 32'(fs_v), 32'h00000000);
        check("emf extra", 32'(emf_x), 32'h00ABCDEF);
        wreg(IDX_CTRL, 32'h00000001);
        repeat (3) @(posedge pclk);
        check("standstill", 32'(enc_z), 32'h00000000);
        $display("test mux done");
    endtask
    task automatic test_active();
        logic signed [31:0] v[4];
        logic e[4];
        v = '{32'sd100, 32'sd101, -32'sd101, -32'sd100};
        e = '{1'b0, 1'b1, 1'b1, 1'b0};
        wreg(IDX_MIN_VEL, 32'h00000064);
        for (int i = 0; i < 4; i++) begin
            vel <= v[i];
            repeat (3) @(posedge pclk);
            check("active", 32'(act), 32'(e[i]));
        end
        vel <= 32'sd101;
        repeat (3) @(posedge pclk);
        rreg(IDX_STATE);
        check("state view", rd, 32'h00000001);
        wreg(IDX_CTRL, 32'h00000003);
        repeat (3) @(posedge pclk);
        check("active cl", 32'(act), 32'h00000000);
        $display("test active done");
    endtask
    task automatic test_stall();
        wreg(IDX_CTRL, 32'h00000001);
        wreg(IDX_STEP_CFG, 32'h00080203);
        wreg(IDX_MASK, 32'h00000001);
        rreg(IDX_STATUS);
        stall_seen = 0;
        cut_seen = 0;
        release_step(16'h000C, 40);
        check("stall short", 32'(stall_seen), 32'h00000001);
        check("cut", 32'(cut_seen), 32'h00000001);
        check("irq set", 32'(irq), 32'h00000001);
        rreg(IDX_STATUS);
        check("status stall", rd, 32'h00000001);
        rreg(IDX_STATUS);
        check("status clear", rd, 32'h00000000);
        check("irq clear", 32'(irq), 32'h00000000);
        stall_seen = 0;
        release_step(16'h0002, 40);
        check("stall blanked", 32'(stall_seen), 32'h00000000);
        wreg(IDX_MASK, 32'h00000000);
        wreg(IDX_LSPTM, 32'h0000003C);
        release_step(16'h0028, 130);
        check("stall long", 32'(stall_seen), 32'h00000000);
        check("irq masked", 32'(irq), 32'h00000000);
        rreg(IDX_STATUS);
        check("low speed", rd, 32'h00000002);
        $display("test stall done");
    endtask

    // ************************************************************
    // Verdict and main sequence.
    // ************************************************************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        vel <= 32'sd1000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_mux();
        test_active();
        vel <= 32'sd1000;
        test_stall();
        report_and_stop();
    end
endmodule // tb_load_dependent_step_config
